// ===== rtl/fperr_map.vh
// Constants for the floating-point error reporting block: codes, vectors and reset values.
// Assumes it is included by bare name from every design file that needs it.
`ifndef FPERR_MAP_VH
`define FPERR_MAP_VH

// ----------------------------------------------------------------------------
// Instruction types presented by the core
// ----------------------------------------------------------------------------
`define FPERR_INSTR_NONFP 2'h0
`define FPERR_INSTR_WAITING 2'h1
`define FPERR_INSTR_NOWAIT 2'h2

// ----------------------------------------------------------------------------
// Exception kinds
// ----------------------------------------------------------------------------
`define FPERR_EXC_INVALID 3'h0
`define FPERR_EXC_DENORMAL 3'h1
`define FPERR_EXC_ZERO_DIV 3'h2
`define FPERR_EXC_OVERFLOW 3'h3
`define FPERR_EXC_UNDERFLOW 3'h4
`define FPERR_EXC_PRECISION 3'h5
`define FPERR_EXC_STACK 3'h6

// ----------------------------------------------------------------------------
// Instruction classes that raised the exception
// ----------------------------------------------------------------------------
`define FPERR_CLS_ARITH 2'h0
`define FPERR_CLS_TRANSC 2'h1
`define FPERR_CLS_STORE 2'h2
`define FPERR_CLS_OTHER 2'h3

// ----------------------------------------------------------------------------
// Vectors, synchroniser depth and reset values
// ----------------------------------------------------------------------------
`define FPERR_NATIVE_VECTOR 8'h10
`define FPERR_SYNC_STAGES 2
`define FPERR_RST_ERROR_N 1'h1
`define FPERR_RST_ZERO 1'h0

`endif

// ===== rtl/fperr_sync.v
// Multi-bit two-flop synchroniser for independent level inputs.
// Assumes each bit is a slow level; no word coherence between bits is given.
`timescale 1ns/10ps
module fperr_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  input wire [WIDTH-1:0] rst_value,
  output wire [WIDTH-1:0] sync_out
);

  // --------------------------------------------------------------------------
  // Stages
  // --------------------------------------------------------------------------
  // Each stage holds its input xor the reset value, so the flops clear to a
  // constant under the asynchronous reset while the output starts at rst_value.
  reg [WIDTH-1:0] stage_a;
  reg [WIDTH-1:0] stage_b;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_a <= {WIDTH{1'b0}};
      stage_b <= {WIDTH{1'b0}};
    end else begin
      stage_a <= async_in ^ rst_value;
      stage_b <= stage_a;
    end
  end

  assign sync_out = stage_b ^ rst_value;

endmodule

// ===== rtl/fperr_core.v
// Floating-point error reporting logic inside the processor: exception
// pending state, legacy error pin, ignore input, stall and native fault.
// Assumes exception, clear and instruction strobes come from logic on clk, and
// that ignore and interrupt inputs are asynchronous pins from the glue.
`timescale 1ns/10ps
`include "fperr_map.vh"
module fperr_core (
  input wire clk,
  input wire rst,
  input wire native_error_mode_bit,
  input wire exc_valid,
  input wire exc_unmasked,
  input wire [2:0] exc_kind,
  input wire [1:0] exc_class,
  input wire exc_clear,
  input wire instr_valid,
  input wire [1:0] instr_type,
  input wire ignore_fp_error_n,
  input wire cpu_interrupt_in,
  output reg fp_error_out_n,
  output reg instr_grant,
  output reg instr_stalled,
  output reg legacy_int_accept,
  output reg native_fault,
  output reg [7:0] native_fault_vector,
  output reg exc_pending
);

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  wire [1:0] pins_sync;
  wire ignore_n_sync;
  wire intreq_sync;

  // Reset value tied high for the ignore pin so the idle level is inactive.
  fperr_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .async_in({ignore_fp_error_n, cpu_interrupt_in}),
    .rst_value(2'h2),
    .sync_out(pins_sync)
  );

  // The ignore pin reads as inactive until the synchroniser has filled after
  // reset; the guard keeps a pin that is still settling from being acted on.
  reg [1:0] sync_fill;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_fill <= 2'h0;
    end else if (sync_fill != 2'h3) begin
      sync_fill <= sync_fill + 2'h1;
    end
  end

  assign ignore_n_sync = (sync_fill == 2'h3) ? pins_sync[1] : 1'b1;
  assign intreq_sync = (sync_fill == 2'h3) ? pins_sync[0] : 1'b0;

  // --------------------------------------------------------------------------
  // Classification of a new exception
  // --------------------------------------------------------------------------
  // Returns 1 for immediate reporting and 0 for deferred reporting.
  // Cases not covered explicitly fall back to deferred, the common method.
  function classify_immediate;
    input [2:0] kind;
    input [1:0] cls;
    begin
      classify_immediate = 1'b0;
      if (kind == `FPERR_EXC_PRECISION) begin
        classify_immediate = 1'b0;
      end else if (cls == `FPERR_CLS_STORE) begin
        classify_immediate = 1'b1;
      end else if (cls == `FPERR_CLS_ARITH) begin
        classify_immediate = 1'b0;
      end else if (cls == `FPERR_CLS_TRANSC &&
                   (kind == `FPERR_EXC_STACK || kind == `FPERR_EXC_INVALID ||
                    kind == `FPERR_EXC_DENORMAL)) begin
        classify_immediate = 1'b1;
      end else if (kind == `FPERR_EXC_OVERFLOW || kind == `FPERR_EXC_UNDERFLOW) begin
        classify_immediate = 1'b0;
      end else begin
        classify_immediate = 1'b0;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Decoded conditions
  // --------------------------------------------------------------------------
  wire legacy_mode;
  wire ignore_active;
  wire new_exc;
  wire new_is_immediate;
  wire waiting_instr;
  wire nowait_instr;

  assign legacy_mode = ~native_error_mode_bit;
  assign ignore_active = legacy_mode & ~ignore_n_sync;
  assign new_exc = exc_valid & exc_unmasked;
  assign new_is_immediate = classify_immediate(exc_kind, exc_class);
  assign waiting_instr = instr_valid & (instr_type == `FPERR_INSTR_WAITING);
  assign nowait_instr = instr_valid & (instr_type == `FPERR_INSTR_NOWAIT);

  // --------------------------------------------------------------------------
  // Pending exception state
  // --------------------------------------------------------------------------
  // A new exception in the cycle of a clear wins, so no event is lost.
  reg pend_immediate;
  reg next_exc_pending;
  reg next_pend_immediate;

  always @* begin
    next_exc_pending = exc_pending;
    next_pend_immediate = pend_immediate;
    if (exc_clear) begin
      next_exc_pending = 1'b0;
      next_pend_immediate = 1'b0;
    end
    if (new_exc) begin
      next_exc_pending = 1'b1;
      next_pend_immediate = (exc_pending & ~exc_clear & pend_immediate) | new_is_immediate;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      exc_pending <= `FPERR_RST_ZERO;
      pend_immediate <= `FPERR_RST_ZERO;
    end else begin
      exc_pending <= next_exc_pending;
      pend_immediate <= next_pend_immediate;
    end
  end

  // --------------------------------------------------------------------------
  // Instruction gating, stall and fault
  // --------------------------------------------------------------------------
  // A stall holds one instruction; further requests while frozen are ignored,
  // since a frozen core issues nothing.
  reg next_instr_grant;
  reg next_instr_stalled;
  reg next_legacy_int_accept;
  reg next_native_fault;
  reg stall_begin;

  always @* begin
    next_instr_grant = 1'b0;
    next_instr_stalled = instr_stalled;
    next_legacy_int_accept = 1'b0;
    next_native_fault = 1'b0;
    stall_begin = 1'b0;
    if (instr_stalled) begin
      if (~legacy_mode || ~exc_pending) begin
        // Mode switched or error removed: the held instruction simply runs.
        next_instr_stalled = 1'b0;
        next_instr_grant = 1'b1;
      end else if (ignore_active) begin
        next_instr_stalled = 1'b0;
        next_instr_grant = 1'b1;
      end else if (intreq_sync) begin
        // The held instruction is abandoned; the handler takes over.
        next_instr_stalled = 1'b0;
        next_legacy_int_accept = 1'b1;
      end
    end else if (nowait_instr) begin
      next_instr_grant = 1'b1;
    end else if (waiting_instr && exc_pending) begin
      if (~legacy_mode) begin
        next_native_fault = 1'b1;
      end else if (ignore_active) begin
        next_instr_grant = 1'b1;
      end else begin
        next_instr_stalled = 1'b1;
        stall_begin = 1'b1;
      end
    end else if (instr_valid) begin
      next_instr_grant = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      instr_grant <= `FPERR_RST_ZERO;
      instr_stalled <= `FPERR_RST_ZERO;
      legacy_int_accept <= `FPERR_RST_ZERO;
      native_fault <= `FPERR_RST_ZERO;
      native_fault_vector <= 8'h00;
    end else begin
      instr_grant <= next_instr_grant;
      instr_stalled <= next_instr_stalled;
      legacy_int_accept <= next_legacy_int_accept;
      native_fault <= next_native_fault;
      if (next_native_fault) begin
        native_fault_vector <= `FPERR_NATIVE_VECTOR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Error output pin
  // --------------------------------------------------------------------------
  // Once asserted the pin holds until the exception is cleared or native mode is selected, even if the
  // ignore input goes active later: the glue relies on the pin staying low to
  // keep its ignore latch set inside the handler.
  reg fp_error_out_n_active;
  reg next_fp_error_out_n_active;

  always @* begin
    next_fp_error_out_n_active = fp_error_out_n_active;
    if (~legacy_mode) begin
      next_fp_error_out_n_active = 1'b0;
    end else if (~next_exc_pending) begin
      next_fp_error_out_n_active = 1'b0;
    end else if (fp_error_out_n_active) begin
      next_fp_error_out_n_active = 1'b1;
    end else if (ignore_active) begin
      next_fp_error_out_n_active = 1'b0;
    end else if (next_pend_immediate) begin
      next_fp_error_out_n_active = 1'b1;
    end else if (stall_begin) begin
      next_fp_error_out_n_active = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_error_out_n_active <= `FPERR_RST_ZERO;
      fp_error_out_n <= `FPERR_RST_ERROR_N;
    end else begin
      fp_error_out_n_active <= next_fp_error_out_n_active;
      fp_error_out_n <= ~next_fp_error_out_n_active;
    end
  end

endmodule

// ===== tb/fperr_core_assertions.sv
// Concurrent checks on the ports of the error reporting core.
// Assumes it is bound to fperr_core and that pins move on clk edges.
`timescale 1ns/10ps
`include "fperr_map.vh"
module fperr_core_assertions (
  input wire clk,
  input wire rst,
  input wire native_error_mode_bit,
  input wire exc_valid,
  input wire exc_unmasked,
  input wire [2:0] exc_kind,
  input wire [1:0] exc_class,
  input wire exc_clear,
  input wire instr_valid,
  input wire [1:0] instr_type,
  input wire ignore_fp_error_n,
  input wire cpu_interrupt_in,
  input wire fp_error_out_n,
  input wire instr_grant,
  input wire instr_stalled,
  input wire legacy_int_accept,
  input wire native_fault,
  input wire [7:0] native_fault_vector,
  input wire exc_pending
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The ignore pin needs three edges to reach the core, so only a settled level counts.
  reg [2:0] ign_hist;
  wire ign_off = ignore_fp_error_n & (&ign_hist);
  wire ign_on = ~ignore_fp_error_n & ~(|ign_hist);
  wire take = instr_valid & ~instr_stalled;
  wire leg = ~native_error_mode_bit;
  wire wt = take & (instr_type == `FPERR_INSTR_WAITING) & exc_pending;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ign_hist <= 3'h7;
    end else begin
      ign_hist <= {ign_hist[1:0], ignore_fp_error_n};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_nowait_grant: assert property (take && instr_type == `FPERR_INSTR_NOWAIT |=> instr_grant)
    else $error("no-wait not granted");
  chk_defer_stall: assert property (wt && leg && ign_off |=> instr_stalled && !fp_error_out_n)
    else $error("no stall with error");
  chk_ignore_run: assert property (wt && leg && ign_on |=> instr_grant && !instr_stalled)
    else $error("ignore did not prevent stall");
  chk_native_fault: assert property (wt && !leg |=> native_fault && native_fault_vector == `FPERR_NATIVE_VECTOR)
    else $error("native fault missing");
  chk_native_pins: assert property (!leg && $past(native_error_mode_bit) |-> fp_error_out_n)
    else $error("error pin used in native mode");
  chk_immed_report: assert property (exc_valid && exc_unmasked && exc_kind == `FPERR_EXC_STACK
    && exc_class == `FPERR_CLS_TRANSC && leg && ign_off |=> !fp_error_out_n && exc_pending) else $error("late report");
  chk_defer_quiet: assert property (exc_valid && exc_unmasked && exc_class == `FPERR_CLS_ARITH && leg
    && fp_error_out_n && !exc_pending && !instr_valid |=> fp_error_out_n) else $error("deferred reported early");
  chk_clear_release: assert property (exc_clear && !exc_valid |=> fp_error_out_n && !exc_pending)
    else $error("clear did not release");
  chk_int_accept: assert property (instr_stalled && leg && exc_pending && ign_off && $rose(cpu_interrupt_in)
    |-> ##[1:4] legacy_int_accept) else $error("interrupt not accepted");
  cover property (instr_stalled ##[1:20] legacy_int_accept);
  cover property (wt && ign_on);
  cover property (native_fault);
endmodule
bind fperr_core fperr_core_assertions u_chk (.clk(clk), .rst(rst), .native_error_mode_bit(native_error_mode_bit),
  .exc_valid(exc_valid), .exc_unmasked(exc_unmasked), .exc_kind(exc_kind), .exc_class(exc_class),
  .exc_clear(exc_clear), .instr_valid(instr_valid), .instr_type(instr_type), .ignore_fp_error_n(ignore_fp_error_n),
  .cpu_interrupt_in(cpu_interrupt_in), .fp_error_out_n(fp_error_out_n), .instr_grant(instr_grant),
  .instr_stalled(instr_stalled), .legacy_int_accept(legacy_int_accept), .native_fault(native_fault),
  .native_fault_vector(native_fault_vector), .exc_pending(exc_pending));

// ===== tb/fperr_glue_model.sv
// Model of the board glue: request latch, ignore latch and a plain interrupt path.
// Assumes one clock shared with the core and a one-cycle port access strobe.
`timescale 1ns/10ps
module fperr_glue_model (
  input wire clk,
  input wire rst,
  input wire fp_error_out_n,
  input wire port_f0_strobe,
  output wire ignore_fp_error_n,
  output wire cpu_interrupt_in
);
  // ----------------------------------------------------------------
  // Latches
  // ----------------------------------------------------------------
  reg [1:0] err_sync;
  reg err_seen;
  reg req;
  reg ign;
  wire err = err_sync[1];
  assign ignore_fp_error_n = ~ign;
  // The controller is modelled as a wire from request line 13 to the core.
  assign cpu_interrupt_in = req;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      err_sync <= 2'h0;
      err_seen <= 1'b0;
      req <= 1'b0;
      ign <= 1'b0;
    end else begin
      err_sync <= {err_sync[0], ~fp_error_out_n};
      err_seen <= err;
      if (port_f0_strobe) begin
        req <= 1'b0;
      end else if (err & ~err_seen) begin
        req <= 1'b1;
      end
      if (~err) begin
        ign <= 1'b0;
      end else if (port_f0_strobe) begin
        ign <= 1'b1;
      end
    end
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the error reporting core with the glue model beside it.
// Assumes the core and glue share one clock; all stimulus except the reset release, 1 ns after an edge, moves on rising edges.
`timescale 1ns/10ps
`include "fperr_map.vh"
`define CMP(a, b) begin checks = checks + 1; if ((a) !== (b)) begin err_count = err_count + 1; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  reg clk = 0, rst = 1, native_error_mode_bit = 0, exc_valid = 0, exc_unmasked = 0, exc_clear = 0;
  reg instr_valid = 0, port_f0_strobe = 0, imm, ign_force_n = 1;
  reg [2:0] exc_kind = 3'h0;
  reg [1:0] exc_class = 2'h0, instr_type = 2'h0;
  wire ign_n, intreq, err_n, grant, stalled, accept, nfault, pending;
  wire [7:0] vec;
  wire ign_core_n = ign_n & ign_force_n;
  integer err_count = 0, checks = 0, cycles = 0, k, c;
  fperr_core u_dut (.clk(clk), .rst(rst), .native_error_mode_bit(native_error_mode_bit), .exc_valid(exc_valid),
    .exc_unmasked(exc_unmasked), .exc_kind(exc_kind), .exc_class(exc_class), .exc_clear(exc_clear),
    .instr_valid(instr_valid), .instr_type(instr_type), .ignore_fp_error_n(ign_core_n), .cpu_interrupt_in(intreq),
    .fp_error_out_n(err_n), .instr_grant(grant), .instr_stalled(stalled), .legacy_int_accept(accept),
    .native_fault(nfault), .native_fault_vector(vec), .exc_pending(pending));
  fperr_glue_model u_glue (.clk(clk), .rst(rst), .fp_error_out_n(err_n), .port_f0_strobe(port_f0_strobe),
    .ignore_fp_error_n(ign_n), .cpu_interrupt_in(intreq));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  always #4 clk = ~clk;
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task instr(input [1:0] t);
    begin
      @(posedge clk) instr_valid <= 1'b1;
      instr_type <= t;
      @(posedge clk) instr_valid <= 1'b0;
      #1;
    end
  endtask
  task exc(input [2:0] kd, input [1:0] cl, input m);
    begin
      @(posedge clk) exc_valid <= 1'b1;
      exc_kind <= kd;
      exc_class <= cl;
      exc_unmasked <= m;
      @(posedge clk) exc_valid <= 1'b0;
      #1;
    end
  endtask
  task clear_exc;
    begin
      @(posedge clk) exc_clear <= 1'b1;
      @(posedge clk) exc_clear <= 1'b0;
      #1;
    end
  endtask
  task port_access;
    begin
      @(posedge clk) port_f0_strobe <= 1'b1;
      @(posedge clk) port_f0_strobe <= 1'b0;
    end
  endtask
  // The wait is bounded so a core that never leaves the stall shows up as a mismatch.
  task wait_accept;
    begin
      for (k = 0; k < 20 && accept !== 1'b1; k = k + 1) begin
        @(posedge clk) #1;
      end
    end
  endtask
  task complete_run;
    begin
      if (err_count == 0 && checks > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  initial begin
    step(16);
    rst <= 1'b0;
    exc(3'h6, 2'h1, 1'b0);
    `CMP(pending, 1'b0)
    for (c = 0; c < 28; c = c + 1) begin
      imm = (c % 4 == 2 && c / 4 != 5) || (c % 4 == 1 && (c / 4 == 0 || c / 4 == 1 || c / 4 == 6));
      exc(c[4:2], c[1:0], 1'b1);
      `CMP(err_n, !imm)
      clear_exc;
      `CMP(err_n, 1'b1)
      step(4);
      port_access;
      step(4);
    end
    exc(`FPERR_EXC_STACK, `FPERR_CLS_TRANSC, 1'b1);
    step(8);
    instr(`FPERR_INSTR_WAITING);
    `CMP(stalled, 1'b1)
    wait_accept;
    `CMP(accept, 1'b1)
    port_access;
    step(5);
    `CMP({intreq, ign_n}, 2'h0)
    instr(`FPERR_INSTR_WAITING);
    `CMP({grant, err_n}, 2'h2)
    clear_exc;
    step(5);
    `CMP(ign_n, 1'b1)
    exc(`FPERR_EXC_INVALID, `FPERR_CLS_ARITH, 1'b1);
    instr(`FPERR_INSTR_NOWAIT);
    `CMP(grant, 1'b1)
    instr(`FPERR_INSTR_NONFP);
    `CMP(grant, 1'b1)
    instr(`FPERR_INSTR_WAITING);
    `CMP({stalled, err_n}, 2'h2)
    wait_accept;
    `CMP(accept, 1'b1)
    clear_exc;
    step(5);
    port_access;
    step(5);
    `CMP({intreq, ign_n}, 2'h1)
    // The bench forces ignore here, since the glue never lets it be active while the error pin is idle.
    @(posedge clk) ign_force_n <= 1'b0;
    step(4);
    exc(`FPERR_EXC_STACK, `FPERR_CLS_TRANSC, 1'b1);
    `CMP({pending, err_n}, 2'h3)
    @(posedge clk) ign_force_n <= 1'b1;
    step(5);
    `CMP(err_n, 1'b0)
    clear_exc;
    step(5);
    port_access;
    step(5);
    @(posedge clk) ign_force_n <= 1'b0;
    step(4);
    exc(`FPERR_EXC_INVALID, `FPERR_CLS_ARITH, 1'b1);
    instr(`FPERR_INSTR_WAITING);
    `CMP({grant, err_n}, 2'h3)
    @(posedge clk) ign_force_n <= 1'b1;
    step(5);
    `CMP(err_n, 1'b1)
    instr(`FPERR_INSTR_WAITING);
    `CMP({stalled, err_n}, 2'h2)
    wait_accept;
    `CMP(accept, 1'b1)
    clear_exc;
    step(5);
    port_access;
    step(5);
    @(posedge clk) native_error_mode_bit <= 1'b1;
    exc(`FPERR_EXC_INVALID, `FPERR_CLS_ARITH, 1'b1);
    instr(`FPERR_INSTR_WAITING);
    `CMP({nfault, err_n}, 2'h3)
    `CMP(vec, `FPERR_NATIVE_VECTOR)
    complete_run;
  end
endmodule
